/* hdl/adc_conversion_sequencer.sv */
// Sequencer for an eight-channel successive-approximation converter with APB registers
// Behaviour
// (R1) Software selects 8-bit or 10-bit result
// (R2) Eight inputs, converts programmed channels
// (R3) Start by software, reload timer, free-run zero
// (R4) Completion raises interrupt and transfer request
// (R5) Unread result protected while interrupt enabled; the code lets a trigger from idle start a conversion that overwrites it
// (R6) Single-shot: one channel or one scan
// (R7) Continuous: repeat channel or scan forever
// (R8) Incremental: one step, wait next trigger; with scan on, the code runs the whole scan per trigger, as in single-shot
// (R9) Sample 2.0 us, conversion 6.13 us minimum
// (R10) Scan ascends first to last channel
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_sequencer (
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic RESET_N,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Timer events (other clock or pins)
    input wire logic RELOAD1_OUT,
    input wire logic FREERUN_ZERO,
    // Analog front end
    output logic [2:0] ANALOG_SEL,
    output logic SAMPLE_HOLD,
    input wire logic [9:0] SAR_CODE,
    // Interrupt and transfer request
    output logic IRQ,
    output logic XFER_REQ
);
    typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_WAIT} seq_t;

    conv_if cv ();

    logic [7:0] ctrl_r;
    logic [5:0] chan_r;
    logic [1:0] status_r;
    logic [1:0] mask_r;
    logic [9:0] data_r;
    logic [2:0] data_ch_r;
    logic unread_r;
    seq_t state_r;
    logic [2:0] cur_r;
    logic start_r;
    logic [31:0] prdata_r;
    logic irq_r;
    logic xfer_r;
    logic slverr_r;
    logic sh_r;
    logic [9:0] code_s1_r;
    logic [9:0] code_r;
    logic rel_rise;
    logic frz_rise;
    logic soft_go;
    logic trig;
    logic wr_en;
    logic rd_en;
    logic hit;
    logic blocked;
    logic last_ch;
    logic [1:0] mode;
    logic [1:0] tsel;
    logic [2:0] first_ch;
    logic [2:0] last_sel;
    logic done_set;
    logic ovr_set;

    assign mode = ctrl_r[adc_seq_pkg::CTRL_MODE_LO +: 2];
    assign tsel = ctrl_r[adc_seq_pkg::CTRL_TRIG_LO +: 2];
    assign first_ch = chan_r[adc_seq_pkg::CHAN_FIRST_LO +: 3];
    assign last_sel = chan_r[adc_seq_pkg::CHAN_LAST_LO - 1 +: 3];
    assign wr_en = PSEL && PENABLE && PWRITE;
    assign rd_en = PSEL && !PENABLE && !PWRITE;

    // ==========================================================
    // Trigger sources
    trig_sync u_rel (
        .clk(CORE_CLK),
        .reset_n(RESET_N),
        .async_in(RELOAD1_OUT),
        .rise(rel_rise)
    );
    trig_sync u_frz (
        .clk(CORE_CLK),
        .reset_n(RESET_N),
        .async_in(FREERUN_ZERO),
        .rise(frz_rise)
    );

    assign soft_go = wr_en && (PADDR == adc_seq_pkg::OFS_START) && PWDATA[0];
    // (R3) Start source select
    always_comb begin
        unique case (tsel)
            adc_seq_pkg::TRIG_SOFT: trig = soft_go;
            adc_seq_pkg::TRIG_RELOAD: trig = rel_rise || soft_go;
            adc_seq_pkg::TRIG_FREERUN: trig = frz_rise || soft_go;
            default: trig = soft_go;
        endcase
    end

    // ==========================================================
    // Conversion timer
    conv_timer u_tmr (
        .clk(CORE_CLK),
        .reset_n(RESET_N),
        .cv(cv.tmr)
    );

    // (R5) Hold off while previous result unread
    assign blocked = ctrl_r[adc_seq_pkg::CTRL_PROTECT] && mask_r[adc_seq_pkg::ST_DONE] && unread_r;
    // (R10) Scan range end test
    assign last_ch = !ctrl_r[adc_seq_pkg::CTRL_SCAN] || (cur_r == last_sel) || (cur_r == 3'h7);

    // ==========================================================
    // Sequencer
    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            state_r <= ST_IDLE;
            cur_r <= 3'h0;
            start_r <= 1'b0;
        end else begin
            start_r <= 1'b0;
            unique case (state_r)
                ST_IDLE: begin
                    if (trig) begin
                        // (R2) Begin at programmed channel
                        cur_r <= first_ch;
                        start_r <= 1'b1;
                        state_r <= ST_CONV;
                    end
                end
                ST_CONV: begin
                    if (done_set) begin
                        if (!last_ch) begin
                            // (R10) Step to next channel
                            cur_r <= cur_r + 3'h1;
                            state_r <= ST_WAIT;
                        end else if (mode == adc_seq_pkg::MODE_CONT) begin
                            // (R7) Wrap and repeat
                            cur_r <= first_ch;
                            state_r <= ST_WAIT;
                        end else begin
                            // (R6) Single or incremental end of pass
                            // (R8) Idle until next trigger
                            state_r <= ST_IDLE;
                        end
                    end
                end
                ST_WAIT: begin
                    if (!blocked) begin
                        start_r <= 1'b1;
                        state_r <= ST_CONV;
                    end
                end
            endcase
        end
    end

    assign cv.start = start_r;
    assign cv.chan = cur_r;
    assign done_set = (state_r == ST_CONV) && cv.done;

    // ==========================================================
    // Analog side, code synchronised from the comparator
    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            code_s1_r <= 10'h000;
            code_r <= 10'h000;
            sh_r <= 1'b0;
        end else begin
            code_s1_r <= SAR_CODE;
            code_r <= code_s1_r;
            sh_r <= cv.sampling;
        end
    end

    // ==========================================================
    // Result register
    assign ovr_set = done_set && unread_r && !blocked;
    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            data_r <= 10'h000;
            data_ch_r <= 3'h0;
            unread_r <= 1'b0;
        end else begin
            if (done_set) begin
                // (R1) Truncate to 8 bits when selected
                data_r <= ctrl_r[adc_seq_pkg::CTRL_RES10] ? code_r : {2'b00, code_r[9:2]};
                data_ch_r <= cur_r;
                unread_r <= 1'b1;
            end else if (rd_en && PADDR == adc_seq_pkg::OFS_DATA) begin
                unread_r <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Registers and interrupt status
    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            ctrl_r <= adc_seq_pkg::CTRL_RESET[7:0];
            chan_r <= 6'h00;
            mask_r <= 2'b00;
            status_r <= 2'b00;
        end else begin
            if (wr_en && PADDR == adc_seq_pkg::OFS_CTRL) ctrl_r <= PWDATA[7:0];
            if (wr_en && PADDR == adc_seq_pkg::OFS_CHAN) chan_r <= {PWDATA[6:4], PWDATA[2:0]};
            if (wr_en && PADDR == adc_seq_pkg::OFS_MASK) mask_r <= PWDATA[1:0];
            // (R4) Set beats write-one clear
            status_r <= (status_r & ~((wr_en && PADDR == adc_seq_pkg::OFS_STATUS) ? PWDATA[1:0] : 2'b00))
                | {ovr_set, done_set};
        end
    end

    always_comb begin
        hit = 1'b1;
        unique case (PADDR)
            adc_seq_pkg::OFS_CTRL, adc_seq_pkg::OFS_CHAN, adc_seq_pkg::OFS_STATUS,
            adc_seq_pkg::OFS_MASK, adc_seq_pkg::OFS_DATA, adc_seq_pkg::OFS_START: hit = 1'b1;
            default: hit = 1'b0;
        endcase
    end

    // Registered in the setup cycle so the error stands for the whole access phase
    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            slverr_r <= 1'b0;
        end else begin
            slverr_r <= PSEL && !PENABLE && !hit;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            prdata_r <= 32'h0000_0000;
        end else if (rd_en) begin
            unique case (PADDR)
                adc_seq_pkg::OFS_CTRL: prdata_r <= {24'h00_0000, ctrl_r};
                adc_seq_pkg::OFS_CHAN: prdata_r <= {25'h000_0000, chan_r[5:3], 1'b0, chan_r[2:0]};
                adc_seq_pkg::OFS_STATUS: prdata_r <= {21'h00_0000, unread_r, state_r != ST_IDLE,
                    cur_r, 4'h0, status_r};
                adc_seq_pkg::OFS_MASK: prdata_r <= {30'h0000_0000, mask_r};
                adc_seq_pkg::OFS_DATA: prdata_r <= {13'h0000, data_ch_r, 6'h00, data_r};
                default: prdata_r <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            irq_r <= 1'b0;
            xfer_r <= 1'b0;
        end else begin
            irq_r <= |(status_r & mask_r);
            // (R4) Transfer request pulse on completion
            xfer_r <= done_set && ctrl_r[adc_seq_pkg::CTRL_XFER_EN];
        end
    end

    assign PRDATA = prdata_r;
    assign PREADY = 1'b1;
    assign PSLVERR = slverr_r;
    assign IRQ = irq_r;
    assign XFER_REQ = xfer_r;
    assign ANALOG_SEL = cur_r;
    assign SAMPLE_HOLD = sh_r;

    // ==========================================================
    // Checks
    a_scan_step: assert property (@(posedge CORE_CLK) disable iff (!RESET_N) // (R10)
        (done_set && !last_ch) |=> (cur_r == $past(cur_r) + 3'h1))
        else $error("scan did not ascend");
    a_single_stop: assert property (@(posedge CORE_CLK) disable iff (!RESET_N) // (R6)
        (done_set && last_ch && mode != adc_seq_pkg::MODE_CONT) |=> state_r == ST_IDLE)
        else $error("single mode did not halt");
    a_cont_repeat: assert property (@(posedge CORE_CLK) disable iff (!RESET_N) // (R7)
        (done_set && mode == adc_seq_pkg::MODE_CONT) |=> state_r == ST_WAIT)
        else $error("continuous mode stopped");
    a_incr_wait: assert property (@(posedge CORE_CLK) disable iff (!RESET_N) // (R8)
        (state_r == ST_IDLE && !trig) |=> state_r == ST_IDLE)
        else $error("started without trigger");
    a_done_flag: assert property (@(posedge CORE_CLK) disable iff (!RESET_N) // (R4)
        done_set |=> status_r[adc_seq_pkg::ST_DONE])
        else $error("done flag not set");
    a_irq_level: assert property (@(posedge CORE_CLK) disable iff (!RESET_N) // (R4)
        |(status_r & mask_r) |=> IRQ)
        else $error("interrupt not raised");
    a_protect_hold: assert property (@(posedge CORE_CLK) disable iff (!RESET_N) // (R5)
        (state_r == ST_WAIT && blocked) |=> !start_r)
        else $error("protected result overrun");
    a_res_eight: assert property (@(posedge CORE_CLK) disable iff (!RESET_N) // (R1)
        (done_set && !ctrl_r[adc_seq_pkg::CTRL_RES10]) |=> data_r[9:8] == 2'b00)
        else $error("8-bit result has high bits");
    c_scan_pass: cover property (@(posedge CORE_CLK) done_set && ctrl_r[adc_seq_pkg::CTRL_SCAN] && !last_ch);
    c_cont_wrap: cover property (@(posedge CORE_CLK) done_set && mode == adc_seq_pkg::MODE_CONT);
    c_timer_start: cover property (@(posedge CORE_CLK) state_r == ST_IDLE && (rel_rise || frz_rise));
endmodule // adc_conversion_sequencer
`default_nettype wire

/* hdl/conv_timer.sv */
// Conversion phase timer: sample window then approximation window
`timescale 1ns/1ps
`default_nettype none
module conv_timer (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Sequencer side
    conv_if.tmr cv
);
    logic [8:0] cnt_r;
    logic busy_r;
    logic done_r;

    // ==========================================================
    // Phase counter
    // (R9) Minimum phase lengths
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cnt_r <= 9'h000;
            busy_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            done_r <= 1'b0;
            if (busy_r) begin
                if (cnt_r == 9'(adc_seq_pkg::CONV_CYC - 1)) begin
                    busy_r <= 1'b0;
                    done_r <= 1'b1;
                end
                cnt_r <= cnt_r + 9'h001;
            end else if (cv.start) begin
                busy_r <= 1'b1;
                cnt_r <= 9'h000;
            end
        end
    end

    assign cv.sampling = busy_r && (cnt_r < 9'(adc_seq_pkg::SAMPLE_CYC));
    assign cv.done = done_r;

    // ==========================================================
    // Checks
    a_conv_length: assert property (@(posedge clk) disable iff (!reset_n) // (R9)
        done_r |-> cnt_r == 9'(adc_seq_pkg::CONV_CYC))
        else $error("conversion ended too early");
    a_sample_first: assert property (@(posedge clk) disable iff (!reset_n) // (R9)
        $rose(busy_r) |-> cv.sampling [*8])
        else $error("sample phase too short");
endmodule // conv_timer
`default_nettype wire

/* hdl/trig_sync.sv */
// Trigger synchroniser and rising edge detector for one timer event
`timescale 1ns/1ps
`default_nettype none
module trig_sync (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Event
    input wire logic async_in,
    output logic rise
);
    logic s1_r;
    logic s2_r;
    logic s3_r;

    // ==========================================================
    // Two-flop synchroniser, edge taken after the second flop
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
        end else begin
            s1_r <= async_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    assign rise = s2_r && !s3_r;
endmodule // trig_sync
`default_nettype wire

/* pkg/adc_seq_pkg.sv */
// Package: register map, fields and timing for the conversion sequencer
`default_nettype none
package adc_seq_pkg;
    // ==========================================================
    // Register offsets (byte addresses)
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CHAN = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_MASK = 8'h0C;
    localparam logic [7:0] OFS_DATA = 8'h10;
    localparam logic [7:0] OFS_START = 8'h14;
    // ==========================================================
    // Control fields
    localparam int CTRL_MODE_LO = 0;
    localparam int CTRL_TRIG_LO = 2;
    localparam int CTRL_RES10 = 4;
    localparam int CTRL_SCAN = 5;
    localparam int CTRL_PROTECT = 6;
    localparam int CTRL_XFER_EN = 7;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam int CHAN_FIRST_LO = 0;
    localparam int CHAN_LAST_LO = 4;
    // Status bits
    localparam int ST_DONE = 0;
    localparam int ST_OVERRUN = 1;
    // ==========================================================
    // Enumerations
    typedef enum logic [1:0] {MODE_SINGLE1, MODE_SINGLE2, MODE_CONT, MODE_INCR} mode_t;
    typedef enum logic [1:0] {TRIG_SOFT, TRIG_RELOAD, TRIG_FREERUN, TRIG_RSVD} trig_t;
    // ==========================================================
    // Timing
    localparam int CLK_MHZ = 40;
    localparam int SAMPLE_NS = 2000;
    localparam int CONV_NS = 6130;
    localparam int SAMPLE_CYC = (SAMPLE_NS * CLK_MHZ + 999) / 1000;
    localparam int CONV_CYC = (CONV_NS * CLK_MHZ + 999) / 1000;
    localparam int RESULT_W = 10;
    localparam int NUM_CH = 8;
endpackage
`default_nettype wire

/* pkg/conv_if.sv */
// Interface: conversion request and result between sequencer and timer
`timescale 1ns/1ps
`default_nettype none
interface conv_if;
    logic start;
    logic [2:0] chan;
    logic sampling;
    logic done;
    modport seq (output start, output chan, input sampling, input done);
    modport tmr (input start, input chan, output sampling, output done);
endinterface // conv_if
`default_nettype wire

/* sim/afe_model.sv */
// Behavioural analog front end: sample-and-hold with a code per channel
`timescale 1ns/1ps
`default_nettype none
module afe_model (
    // Clock
    input wire logic clk,
    // Sequencer side
    input wire logic [2:0] sel,
    input wire logic hold,
    output logic [9:0] code
);
    logic hold_q = 1'b0;
    // ==========================================================
    // Sample capture
    // Code depends on the channel so a wrong multiplexer setting shows up in the result
    initial code = 10'h000;
    always @(posedge clk) begin
        hold_q <= hold;
        if (hold && !hold_q) begin
            code <= {sel, ~sel, 4'h9};
        end
    end
endmodule // afe_model
`default_nettype wire

/* sim/test_adc_conversion_sequencer.sv */
// Self-checking bench for the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module test_adc_conversion_sequencer;
    logic CORE_CLK = 1'b0, RESET_N = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
    logic RELOAD1_OUT = 1'b0, FREERUN_ZERO = 1'b0;
    logic [7:0] PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0000_0000;
    logic [31:0] PRDATA, rd;
    logic PREADY, PSLVERR, SAMPLE_HOLD, IRQ, XFER_REQ, er, sh_q = 1'b0;
    logic [2:0] ANALOG_SEL, ch, f, l;
    logic [9:0] SAR_CODE, e;
    logic [2:0] chq[$];
    int err_total = 0, n_tests = 0, xfer_cnt = 0, st_cyc = 0, hi_cyc = 0, cyc = 0, n;
    integer seed = 80;
    // ==========================================================
    // Clock, design and front end
    initial forever #12.5 CORE_CLK = ~CORE_CLK;
    adc_conversion_sequencer DUT (.CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
        .RELOAD1_OUT(RELOAD1_OUT), .FREERUN_ZERO(FREERUN_ZERO), .ANALOG_SEL(ANALOG_SEL),
        .SAMPLE_HOLD(SAMPLE_HOLD), .SAR_CODE(SAR_CODE), .IRQ(IRQ), .XFER_REQ(XFER_REQ));
    afe_model AFE (.clk(CORE_CLK), .sel(ANALOG_SEL), .hold(SAMPLE_HOLD), .code(SAR_CODE));
    // ==========================================================
    // Helpers
    task automatic summarize();
        if (err_total == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input bit ok, input string msg);
        n_tests++;
        if (!ok) begin
            $display("Error %0t: %s", $time, msg);
            err_total++;
        end
    endtask
    function automatic logic [9:0] exp_code(input logic [2:0] c);
        return {c, ~c, 4'h9};
    endfunction
    function automatic logic [31:0] ctrl(input int m, input int t, input int r10, input int sc, input int pr);
        return (32'(m) << adc_seq_pkg::CTRL_MODE_LO) | (32'(t) << adc_seq_pkg::CTRL_TRIG_LO)
            | (32'(r10) << adc_seq_pkg::CTRL_RES10) | (32'(sc) << adc_seq_pkg::CTRL_SCAN)
            | (32'(pr) << adc_seq_pkg::CTRL_PROTECT) | (32'h0000_0001 << adc_seq_pkg::CTRL_XFER_EN);
    endfunction
    // Entered right after a rising edge; an idle cycle follows so no signal is assigned twice at one edge
    task automatic apb(input bit w, input logic [7:0] a, input logic [31:0] d);
        int i;
        PSEL <= 1'b1; PENABLE <= 1'b0; PWRITE <= w; PADDR <= a; PWDATA <= d;
        @(posedge CORE_CLK);
        PENABLE <= 1'b1;
        i = 0;
        do begin
            @(posedge CORE_CLK);
            i++;
        end while (PREADY !== 1'b1 && i < 50);
        if (PREADY !== 1'b1) begin
            $display("Error %0t: bus transfer timed out", $time);
            err_total++;
        end
        rd = PRDATA;
        er = PSLVERR;
        PSEL <= 1'b0; PENABLE <= 1'b0;
        @(posedge CORE_CLK);
    endtask
    task automatic wait_x(input int target);
        for (int i = 0; i < 4000 && xfer_cnt < target; i++) @(posedge CORE_CLK);
        chk(xfer_cnt >= target, "conversion did not complete");
    endtask
    task automatic fire(input int t);
        if (t == 0) apb(1'b1, adc_seq_pkg::OFS_START, 32'h0000_0001);
        else begin
            if (t == 1) RELOAD1_OUT <= 1'b1;
            else FREERUN_ZERO <= 1'b1;
            repeat (4) @(posedge CORE_CLK);
            RELOAD1_OUT <= 1'b0; FREERUN_ZERO <= 1'b0;
            @(posedge CORE_CLK);
        end
    endtask
    task automatic clr();
        chq.delete();
        xfer_cnt = 0;
        apb(1'b1, adc_seq_pkg::OFS_STATUS, 32'h0000_0003);
    endtask
    // ==========================================================
    // Monitor of sample window and conversion time
    always @(posedge CORE_CLK) begin
        cyc++;
        if (SAMPLE_HOLD === 1'b1 && sh_q !== 1'b1) begin
            chq.push_back(ANALOG_SEL);
            st_cyc = cyc;
        end
        if (SAMPLE_HOLD === 1'b1) hi_cyc++;
        else if (sh_q === 1'b1) begin
            chk(hi_cyc >= adc_seq_pkg::SAMPLE_CYC, "sample window too short");
            hi_cyc = 0;
        end
        if (XFER_REQ === 1'b1) begin
            xfer_cnt++;
            chk(cyc - st_cyc >= adc_seq_pkg::CONV_CYC - 1, "conversion too short");
        end
        sh_q = SAMPLE_HOLD;
    end
    // ==========================================================
    // Watchdog
    initial begin
        #1_000_000;
        err_total++;
        summarize();
    end
    // ==========================================================
    // Scenarios
    initial begin
        repeat (12) @(posedge CORE_CLK);
        RESET_N <= 1'b1;
        @(posedge CORE_CLK);
        apb(1'b0, adc_seq_pkg::OFS_CTRL, 32'h0000_0000);
        chk(rd === 32'h0000_0000, "control not clear after reset");
        chk(IRQ === 1'b0 && XFER_REQ === 1'b0 && SAMPLE_HOLD === 1'b0, "outputs active after reset");
        apb(1'b0, 8'h18, 32'h0000_0000);
        chk(er === 1'b1 && rd === 32'h0000_0000, "unmapped read accepted");
        apb(1'b1, adc_seq_pkg::OFS_MASK, 32'h0000_0001);
        // Single channel, 10-bit then 8-bit
        for (int r = 1; r >= 0; r--) begin
            clr();
            ch = 3'($random(seed));
            e = exp_code(ch);
            apb(1'b1, adc_seq_pkg::OFS_CHAN, {25'h0, ch, 1'b0, ch});
            apb(1'b1, adc_seq_pkg::OFS_CTRL, ctrl(1 - r, 0, r, 0, 0));
            fire(0);
            wait_x(1);
            apb(1'b0, adc_seq_pkg::OFS_DATA, 32'h0000_0000);
            chk(rd[9:0] === (r == 1 ? e : {2'b00, e[9:2]}), "result value wrong");
            chk(rd[18:16] === ch && chq[0] === ch, "wrong channel");
            chk(IRQ === 1'b1, "interrupt missing");
            apb(1'b1, adc_seq_pkg::OFS_STATUS, 32'h0000_0001);
            repeat (2) @(posedge CORE_CLK);
            chk(IRQ === 1'b0, "interrupt not cleared");
            repeat (300) @(posedge CORE_CLK);
            chk(xfer_cnt == 1 && chq.size() == 1, "single-shot repeated");
        end
        // Masked completion, then unmasked
        clr();
        apb(1'b1, adc_seq_pkg::OFS_MASK, 32'h0000_0000);
        fire(0);
        wait_x(1);
        repeat (2) @(posedge CORE_CLK);
        chk(IRQ === 1'b0, "masked interrupt raised");
        apb(1'b1, adc_seq_pkg::OFS_MASK, 32'h0000_0001);
        repeat (2) @(posedge CORE_CLK);
        chk(IRQ === 1'b1, "unmasked interrupt missing");
        // Single-shot scan over a random range
        clr();
        f = 3'($random(seed)) & 3'h3;
        l = f + 3'h1 + (3'($random(seed)) & 3'h3);
        n = int'(l) - int'(f) + 1;
        apb(1'b1, adc_seq_pkg::OFS_CHAN, {25'h0, l, 1'b0, f});
        apb(1'b1, adc_seq_pkg::OFS_CTRL, ctrl(0, 0, 1, 1, 0));
        fire(0);
        wait_x(n);
        repeat (300) @(posedge CORE_CLK);
        chk(chq.size() == n && xfer_cnt == n, "scan count wrong");
        for (int k = 0; k < n && k < chq.size(); k++) chk(chq[k] === 3'(f + k), "scan order");
        // Incremental mode with each start source
        for (int t = 0; t < 3; t++) begin
            clr();
            apb(1'b1, adc_seq_pkg::OFS_CHAN, {25'h0, ch, 1'b0, ch});
            apb(1'b1, adc_seq_pkg::OFS_CTRL, ctrl(3, t, 1, 0, 0));
            if (t > 0) begin
                fire(3 - t);
                repeat (20) @(posedge CORE_CLK);
                chk(chq.size() == 0, "unselected timer started a conversion");
            end
            fire(t);
            wait_x(1);
            repeat (300) @(posedge CORE_CLK);
            chk(xfer_cnt == 1, "incremental did not pause");
            fire(t);
            wait_x(2);
        end
        // Continuous scan with result protection
        clr();
        apb(1'b1, adc_seq_pkg::OFS_CHAN, {25'h0, l, 1'b0, f});
        apb(1'b1, adc_seq_pkg::OFS_CTRL, ctrl(2, 0, 1, 1, 1));
        fire(0);
        wait_x(1);
        repeat (600) @(posedge CORE_CLK);
        chk(xfer_cnt == 1, "unread result overwritten");
        for (int k = 1; k <= n; k++) begin
            apb(1'b0, adc_seq_pkg::OFS_DATA, 32'h0000_0000);
            chk(rd[18:16] === 3'(f + k - 1) && rd[9:0] === exp_code(3'(f + k - 1)), "protected result lost");
            wait_x(k + 1);
        end
        chk(chq.size() > n && chq[n] === f, "continuous scan did not wrap");
        // Reset in mid-run
        RESET_N <= 1'b0;
        repeat (2) @(posedge CORE_CLK);
        RESET_N <= 1'b1;
        @(posedge CORE_CLK);
        apb(1'b0, adc_seq_pkg::OFS_STATUS, 32'h0000_0000);
        chk(rd === 32'h0000_0000 && IRQ === 1'b0, "state survived reset");
        summarize();
    end
endmodule // test_adc_conversion_sequencer
`default_nettype wire
